// ==== design/dual_prescaled_timer_counters.sv ====
// Two 8-bit timer/counters with prescalers behind an APB slave
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "timer_defines.svh"
module dual_prescaled_timer_counters (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input timer_pkg::apb_addr_t paddr,
   input timer_pkg::apb_data_t pwdata,
   output timer_pkg::apb_data_t prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_zero_count_pin,
   input wire logic timer2_prescaler_source,
   output timer_pkg::count_t timer0_value,
   output timer_pkg::count_t timer2_value
);
   import timer_pkg::*;

   // ==========================================================
   // Declarations
   clk_sel_t timer0_clock_select;
   clk_sel_t timer2_clock_select;
   logic timer2_clear_on_match;
   logic timer2_pwm_mode;
   count_t timer0_count;
   count_t timer2_count_value;
   count_t timer2_compare;
   count_dir_t dir;
   count_dir_t next_dir;
   count_t next_timer0_count;
   count_t next_timer2_count;
   apb_data_t next_prdata;
   taps_t t0_taps;
   taps_t t2_taps;
   logic pin_rise;
   logic pin_fall;
   logic src_rise;
   logic t0_tick;
   logic t2_tick;
   logic setup_phase;
   logic wr_access;
   logic hit_t0_ctrl;
   logic hit_t0_count;
   logic hit_t2_ctrl;
   logic hit_t2_count;
   logic hit_t2_compare;
   logic mapped;
   logic wr_t0_ctrl;
   logic wr_t2_ctrl;
   logic wr_t2_count;
   logic wr_t2_compare;
   logic t2_match;
   apb_data_t t0_ctrl_word;
   apb_data_t t2_ctrl_word;

   // ==========================================================
   // Tap selection functions
   // Timer0 taps come from the main clock prescaler
   function automatic logic pick_t0(input clk_sel_t sel, input taps_t taps,
                                    input logic rise, input logic fall);
      logic tick;
      tick = 1'b0;
      unique case (sel)
         `CS_STOP: tick = 1'b0;
         `CS_DIV1: tick = taps[`TAP_1];
         `T0_CS_DIV8: tick = taps[`TAP_8];
         `T0_CS_DIV64: tick = taps[`TAP_64];
         `T0_CS_DIV256: tick = taps[`TAP_256];
         `T0_CS_DIV1024: tick = taps[`TAP_1024];
         `T0_CS_FALL: tick = fall;
         `T0_CS_RISE: tick = rise;
      endcase
      return tick;
   endfunction : pick_t0

   // Timer2 taps come from its own source prescaler
   function automatic logic pick_t2(input clk_sel_t sel, input taps_t taps);
      logic tick;
      tick = 1'b0;
      unique case (sel)
         `CS_STOP: tick = 1'b0;
         `CS_DIV1: tick = taps[`TAP_1];
         `T2_CS_DIV8: tick = taps[`TAP_8];
         `T2_CS_DIV32: tick = taps[`TAP_32];
         `T2_CS_DIV64: tick = taps[`TAP_64];
         `T2_CS_DIV128: tick = taps[`TAP_128];
         `T2_CS_DIV256: tick = taps[`TAP_256];
         `T2_CS_DIV1024: tick = taps[`TAP_1024];
      endcase
      return tick;
   endfunction : pick_t2

   // ==========================================================
   // Pin synchronisers
   // sync and edge detect
   pin_edge_sync count_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(timer_zero_count_pin),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Timer2 source is slow against pclk; only its rising edges count
   pin_edge_sync source_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(timer2_prescaler_source),
      .rise(src_rise),
      .fall()
   );

   // ==========================================================
   // Prescalers
   // taps straight from pclk
   tick_prescaler t0_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .tick_in(1'b1),
      .taps(t0_taps)
   );

   tick_prescaler t2_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .tick_in(src_rise),
      .taps(t2_taps)
   );

   assign t0_tick = pick_t0(timer0_clock_select, t0_taps, pin_rise, pin_fall);
   assign t2_tick = pick_t2(timer2_clock_select, t2_taps);

   // ==========================================================
   // APB decode
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign hit_t0_ctrl = (paddr == `ADDR_T0_CTRL);
   assign hit_t0_count = (paddr == `ADDR_T0_COUNT);
   assign hit_t2_ctrl = (paddr == `ADDR_T2_CTRL);
   assign hit_t2_count = (paddr == `ADDR_T2_COUNT);
   assign hit_t2_compare = (paddr == `ADDR_T2_COMPARE);
   assign mapped = hit_t0_ctrl || hit_t0_count || hit_t2_ctrl ||
                   hit_t2_count || hit_t2_compare;
   assign wr_t0_ctrl = wr_access && hit_t0_ctrl;
   assign wr_t2_ctrl = wr_access && hit_t2_ctrl;
   assign wr_t2_count = wr_access && hit_t2_count;
   assign wr_t2_compare = wr_access && hit_t2_compare;

   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Read words; unused upper bits read as zero
   // reserved bits read zero
   assign t0_ctrl_word = {29'h0000_0000, timer0_clock_select};
   assign t2_ctrl_word = {25'h000_0000, timer2_pwm_mode, 2'h0,
                          timer2_clear_on_match, timer2_clock_select};
   assign next_prdata = hit_t0_ctrl ? t0_ctrl_word :
                        hit_t0_count ? {24'h00_0000, timer0_count} :
                        hit_t2_ctrl ? t2_ctrl_word :
                        hit_t2_count ? {24'h00_0000, timer2_count_value} :
                        hit_t2_compare ? {24'h00_0000, timer2_compare} :
                        32'h0000_0000;

   // Read data latched in setup; the count may move one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_clock_select <= `CS_RESET;
         timer2_clock_select <= `CS_RESET;
         timer2_clear_on_match <= 1'b0;
         timer2_pwm_mode <= 1'b0;
         timer2_compare <= `COMPARE_RESET;
      end else begin
         if (wr_t0_ctrl) begin
            timer0_clock_select <= pwdata[`CS_MSB:0];
         end
         if (wr_t2_ctrl) begin
            timer2_clock_select <= pwdata[`CS_MSB:0];
            timer2_clear_on_match <= pwdata[`CTC_BIT];
            timer2_pwm_mode <= pwdata[`PWM_BIT];
         end
         if (wr_t2_compare) begin
            timer2_compare <= pwdata[7:0];
         end
      end
   end

   // ==========================================================
   // Timer0 counter
   // stop code gates the count
   assign next_timer0_count = t0_tick ? timer0_count + `COUNT_ONE : timer0_count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer0_count <= `COUNT_ZERO;
      end else begin
         timer0_count <= next_timer0_count;
      end
   end

   // ==========================================================
   // Timer2 next-state
   assign t2_match = (timer2_count_value == timer2_compare);

   always_comb begin
      next_timer2_count = timer2_count_value;
      next_dir = dir;
      if (wr_t2_count) begin
         // write wins, count resumes next tick
         next_timer2_count = pwdata[7:0];
      end else if (t2_tick) begin
         if (timer2_pwm_mode && timer2_clear_on_match) begin
            next_timer2_count = timer2_count_value + `COUNT_ONE;
         end else if (timer2_pwm_mode) begin
            // reverse at 255 and at 0
            unique case (dir)
               DIR_UP: begin
                  if (timer2_count_value == `COUNT_MAX) begin
                     next_dir = DIR_DOWN;
                     next_timer2_count = timer2_count_value - `COUNT_ONE;
                  end else begin
                     next_timer2_count = timer2_count_value + `COUNT_ONE;
                  end
               end
               DIR_DOWN: begin
                  if (timer2_count_value == `COUNT_ZERO) begin
                     next_dir = DIR_UP;
                     next_timer2_count = timer2_count_value + `COUNT_ONE;
                  end else begin
                     next_timer2_count = timer2_count_value - `COUNT_ONE;
                  end
               end
            endcase
         end else if (timer2_clear_on_match && t2_match) begin
            // clear on the tick after match
            next_timer2_count = `COUNT_ZERO;
         end else begin
            next_timer2_count = timer2_count_value + `COUNT_ONE;
         end
      end
      if (!timer2_pwm_mode) begin
         next_dir = DIR_UP;
      end
   end

   // Timer2 count and direction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer2_count_value <= `COUNT_ZERO;
         dir <= DIR_UP;
      end else begin
         timer2_count_value <= next_timer2_count;
         dir <= next_dir;
      end
   end

   assign timer0_value = timer0_count;
   assign timer2_value = timer2_count_value;

   // ==========================================================
   // Assertions
   sequence s_t2_tick_nowrite;
      t2_tick && !wr_t2_count;
   endsequence

   sequence s_ctc_match;
      !timer2_pwm_mode && timer2_clear_on_match && t2_match;
   endsequence

   // main clock code counts every cycle
   a_t0_div1_count: assert property (@(posedge pclk) disable iff (!presetn)
      (timer0_clock_select == `CS_DIV1) |=> (timer0_count == $past(timer0_count) + `COUNT_ONE))
      else $error("timer0 did not count on main clock");

   a_t0_ctrl_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && hit_t0_ctrl) |-> (prdata[31:3] == 29'h0000_0000))
      else $error("timer0 control reserved bits not zero");

   a_t0_pin_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (timer0_clock_select == `T0_CS_RISE && pin_rise) |=>
      (timer0_count == $past(timer0_count) + `COUNT_ONE))
      else $error("timer0 missed rising pin edge");

   a_t0_pin_fall_only: assert property (@(posedge pclk) disable iff (!presetn)
      (timer0_clock_select == `T0_CS_FALL && !pin_fall) |=> $stable(timer0_count))
      else $error("timer0 counted without falling edge");

   a_t0_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (timer0_clock_select == `CS_STOP) [*2] |=> $stable(timer0_count))
      else $error("timer0 moved while stopped");

   a_t2_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ctc_match and s_t2_tick_nowrite) |=> (timer2_count_value == `COUNT_ZERO))
      else $error("timer2 not cleared after match");

   // no clear without the control bit
   a_t2_no_ctc: assert property (@(posedge pclk) disable iff (!presetn)
      (!timer2_pwm_mode && !timer2_clear_on_match && t2_tick && !wr_t2_count) |=>
      (timer2_count_value == $past(timer2_count_value) + `COUNT_ONE))
      else $error("timer2 changed wrongly without clear bit");

   // compare value stands until the next tick
   a_t2_hold_compare: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ctc_match and (!t2_tick && !wr_t2_count)) |=>
      (timer2_count_value == $past(timer2_compare)))
      else $error("timer2 left compare value early");

   // wrap mode rolls over to zero
   a_t2_pwm_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (timer2_pwm_mode && timer2_clear_on_match && timer2_count_value == `COUNT_MAX
       && t2_tick && !wr_t2_count) |=> (timer2_count_value == `COUNT_ZERO))
      else $error("timer2 did not wrap at maximum");

   a_t2_pwm_turn: assert property (@(posedge pclk) disable iff (!presetn)
      (timer2_pwm_mode && !timer2_clear_on_match && dir == DIR_UP &&
       timer2_count_value == `COUNT_MAX) and s_t2_tick_nowrite |=>
      (timer2_count_value == `COUNT_MAX - `COUNT_ONE && dir == DIR_DOWN))
      else $error("timer2 did not reverse at maximum");

   a_t2_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (timer2_clock_select == `CS_STOP && !wr_t2_count) |=> $stable(timer2_count_value))
      else $error("timer2 moved while stopped");

   a_t2_write_load: assert property (@(posedge pclk) disable iff (!presetn)
      wr_t2_count |=> (timer2_count_value == $past(pwdata[7:0])))
      else $error("timer2 count write lost");
endmodule : dual_prescaled_timer_counters

// ==== design/pin_edge_sync.sv ====
// Three-flop synchroniser with agreement filter and edge strobes
`timescale 1ns/100ps
module pin_edge_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic level;
   logic agree;

   // ==========================================================
   // Synchroniser chain; stage1 feeds stage2 only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level <= 1'b0;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         if (agree) begin
            level <= stage3;
         end
      end
   end

   // Change counts only once stages two and three agree
   assign agree = (stage2 == stage3);
   assign rise = agree && stage3 && !level;
   assign fall = agree && !stage3 && level;
endmodule : pin_edge_sync

// ==== design/tick_prescaler.sv ====
// Ten-bit prescaler giving strobes at 1, 8, 32, 64, 128, 256, 1024
`timescale 1ns/100ps
`include "timer_defines.svh"
module tick_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick_in,
   output timer_pkg::taps_t taps
);
   import timer_pkg::*;
   logic [9:0] count;

   // ==========================================================
   // Free-running divider, advanced by each source tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= `PRESCALE_RESET;
      end else if (tick_in) begin
         count <= count + `PRESCALE_ONE;
      end
   end

   // A tap fires on the tick that completes its period
   assign taps[`TAP_1] = tick_in;
   assign taps[`TAP_8] = tick_in && ((count & `MASK_8) == `MASK_8);
   assign taps[`TAP_32] = tick_in && ((count & `MASK_32) == `MASK_32);
   assign taps[`TAP_64] = tick_in && ((count & `MASK_64) == `MASK_64);
   assign taps[`TAP_128] = tick_in && ((count & `MASK_128) == `MASK_128);
   assign taps[`TAP_256] = tick_in && ((count & `MASK_256) == `MASK_256);
   assign taps[`TAP_1024] = tick_in && ((count & `MASK_1024) == `MASK_1024);
endmodule : tick_prescaler

// ==== design/timer_defines.svh ====
// Offsets, codes, masks and reset values for the dual timer/counters
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ==========================================================
// Register byte addresses
`define ADDR_T0_CTRL 12'h000
`define ADDR_T0_COUNT 12'h004
`define ADDR_T2_CTRL 12'h008
`define ADDR_T2_COUNT 12'h00C
`define ADDR_T2_COMPARE 12'h010

// ==========================================================
// Control fields
`define CS_MSB 2
`define CTC_BIT 3
`define PWM_BIT 6
`define T2_CTRL_MSB 6

// ==========================================================
// Clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define T0_CS_DIV8 3'h2
`define T0_CS_DIV64 3'h3
`define T0_CS_DIV256 3'h4
`define T0_CS_DIV1024 3'h5
`define T0_CS_FALL 3'h6
`define T0_CS_RISE 3'h7
`define T2_CS_DIV8 3'h2
`define T2_CS_DIV32 3'h3
`define T2_CS_DIV64 3'h4
`define T2_CS_DIV128 3'h5
`define T2_CS_DIV256 3'h6
`define T2_CS_DIV1024 3'h7

// ==========================================================
// Prescaler taps and masks
`define TAP_1 0
`define TAP_8 1
`define TAP_32 2
`define TAP_64 3
`define TAP_128 4
`define TAP_256 5
`define TAP_1024 6
`define MASK_8 10'h007
`define MASK_32 10'h01F
`define MASK_64 10'h03F
`define MASK_128 10'h07F
`define MASK_256 10'h0FF
`define MASK_1024 10'h3FF

// ==========================================================
// Values
`define COUNT_MAX 8'hFF
`define COUNT_ZERO 8'h00
`define COUNT_ONE 8'h01
`define CS_RESET 3'h0
`define COMPARE_RESET 8'h00
`define PRESCALE_RESET 10'h000
`define PRESCALE_ONE 10'h001

`endif

// ==== design/timer_pkg.sv ====
// Types shared by the dual timer/counter design
package timer_pkg;
   typedef logic [7:0] count_t;
   typedef logic [2:0] clk_sel_t;
   typedef logic [11:0] apb_addr_t;
   typedef logic [31:0] apb_data_t;
   typedef logic [6:0] taps_t;
   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;
endpackage : timer_pkg

// ==== testbench/pin_source_model.sv ====
// Far-side model: external count pin and timer2 source clock
`timescale 1ns/100ps
module pin_source_model (
   input wire logic pclk,
   output logic timer_zero_count_pin,
   output logic timer2_prescaler_source
);
   // ==========================================================
   // Idle levels
   // Both lines rest low between bursts; the source never runs free
   initial begin
      timer_zero_count_pin = 1'b0;
      timer2_prescaler_source = 1'b0;
   end

   // ==========================================================
   // Pin pulses
   // Six cycles each level, well clear of the filter's agreement window
   task pulse_pin(input int n);
      repeat (n) begin
         @(posedge pclk);
         timer_zero_count_pin <= 1'b1;
         repeat (6) @(posedge pclk);
         timer_zero_count_pin <= 1'b0;
         repeat (5) @(posedge pclk);
      end
   endtask : pulse_pin

   // ==========================================================
   // Source ticks
   // Three high, three low: slower than pclk/2 after the filter
   task run_source(input int n);
      repeat (n) begin
         @(posedge pclk);
         timer2_prescaler_source <= 1'b1;
         repeat (3) @(posedge pclk);
         timer2_prescaler_source <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask : run_source
endmodule : pin_source_model

// ==== testbench/tb_dual_prescaled_timer_counters.sv ====
// Self-checking bench for the dual timer/counters over APB
`timescale 1ns/100ps
`include "timer_defines.svh"
module tb_dual_prescaled_timer_counters;
   import timer_pkg::*;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   apb_addr_t paddr;
   apb_data_t pwdata;
   apb_data_t prdata;
   logic pready;
   logic pslverr;
   logic count_pin;
   logic src;
   count_t timer0_value;
   count_t timer2_value;
   int n_errors;
   int cmp_count;
   int cycles = 0;
   apb_data_t rd;
   logic err;
   count_t v0;
   clk_sel_t t0_sel [6] = '{`CS_DIV1, `T0_CS_DIV8, `T0_CS_DIV64, `T0_CS_DIV256,
                            `T0_CS_DIV1024, `CS_STOP};
   int t0_win [6] = '{200, 800, 256, 512, 2048, 100};
   count_t t0_exp [6] = '{8'hC8, 8'h64, 8'h04, 8'h02, 8'h02, 8'h00};
   int t2_ticks [8] = '{10, 10, 64, 64, 128, 256, 256, 1024};
   count_t t2_exp [8] = '{8'h00, 8'h0A, 8'h08, 8'h02, 8'h02, 8'h02, 8'h01, 8'h01};

   dual_prescaled_timer_counters u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_zero_count_pin(count_pin),
      .timer2_prescaler_source(src), .timer0_value(timer0_value),
      .timer2_value(timer2_value)
   );

   pin_source_model u_partner (
      .pclk(pclk),
      .timer_zero_count_pin(count_pin),
      .timer2_prescaler_source(src)
   );

   // ==========================================================
   // Clock, reset and hang guard
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Ceiling sits well above the ~15k cycles the tests take
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end

   // ==========================================================
   // Comparison and verdict
   task check(input apb_data_t seen, input apb_data_t exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task final_report();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // ==========================================================
   // APB master
   // Request held until pready is seen high at a rising edge
   task apb_xfer(input logic wr, input apb_addr_t a, input apb_data_t d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb_xfer

   task apb_write(input apb_addr_t a, input apb_data_t d);
      apb_xfer(1'b1, a, d);
   endtask : apb_write

   task apb_read(input apb_addr_t a);
      apb_xfer(1'b0, a, 32'h00000000);
   endtask : apb_read

   // One source tick, then the count once the synchroniser has settled
   task step2(input count_t exp);
      u_partner.run_source(1);
      repeat (8) @(posedge pclk);
      check({24'h000000, timer2_value}, {24'h000000, exp});
   endtask : step2

   // ==========================================================
   // Main sequence
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      presetn = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state, read-only count, unmapped place
      apb_read(`ADDR_T2_COMPARE);
      check(rd, 32'h00000000);
      // Mapped access answers without error, ready already high
      check({31'h00000000, err}, 32'h00000000);
      check({31'h00000000, pready}, 32'h00000001);
      apb_write(`ADDR_T0_COUNT, 32'h000000AA);
      apb_read(`ADDR_T0_COUNT);
      check(rd, 32'h00000000);
      apb_read(12'h014);
      check({31'h00000000, err}, 32'h00000001);
      check(rd, 32'h00000000);
      apb_write(`ADDR_T0_CTRL, 32'hFFFFFFF8);
      apb_read(`ADDR_T0_CTRL);
      check(rd, 32'h00000000);
      apb_write(`ADDR_T0_CTRL, 32'h000000FF);
      apb_read(`ADDR_T0_CTRL);
      check(rd, 32'h00000007);
      // Timer0 main-clock taps and stop, counted over whole windows
      for (int i = 0; i < 6; i++) begin
         apb_write(`ADDR_T0_CTRL, {29'h00000000, t0_sel[i]});
         @(posedge pclk);
         v0 = timer0_value;
         repeat (t0_win[i]) @(posedge pclk);
         check({24'h000000, timer0_value - v0}, {24'h000000, t0_exp[i]});
      end
      // Timer0 on pin edges, rising then falling
      apb_write(`ADDR_T0_CTRL, {29'h00000000, `T0_CS_RISE});
      v0 = timer0_value;
      u_partner.pulse_pin(5);
      repeat (10) @(posedge pclk);
      check({24'h000000, timer0_value - v0}, 32'h00000005);
      apb_write(`ADDR_T0_CTRL, {29'h00000000, `T0_CS_FALL});
      v0 = timer0_value;
      u_partner.pulse_pin(3);
      repeat (10) @(posedge pclk);
      check({24'h000000, timer0_value - v0}, 32'h00000003);
      // Timer2 select codes over whole tick windows
      for (int i = 0; i < 8; i++) begin
         apb_write(`ADDR_T2_CTRL, i);
         v0 = timer2_value;
         u_partner.run_source(t2_ticks[i]);
         repeat (10) @(posedge pclk);
         check({24'h000000, timer2_value - v0}, {24'h000000, t2_exp[i]});
      end
      // Count register write, read back, resume from written value
      apb_write(`ADDR_T2_CTRL, 32'h00000000);
      apb_write(`ADDR_T2_COUNT, 32'h00000040);
      apb_read(`ADDR_T2_COUNT);
      check(rd, 32'h00000040);
      apb_write(`ADDR_T2_CTRL, 32'h00000001);
      step2(8'h41);
      // Clear on match: C-1, C, 0, 1
      apb_write(`ADDR_T2_COMPARE, 32'h00000005);
      apb_write(`ADDR_T2_COUNT, 32'h00000003);
      apb_write(`ADDR_T2_CTRL, 32'h00000009);
      step2(8'h04);
      step2(8'h05);
      step2(8'h00);
      step2(8'h01);
      // Match without clear leaves counting alone
      apb_write(`ADDR_T2_CTRL, 32'h00000001);
      apb_write(`ADDR_T2_COUNT, 32'h00000004);
      step2(8'h05);
      step2(8'h06);
      // PWM with clear bit wraps at 255
      apb_write(`ADDR_T2_CTRL, 32'h00000000);
      apb_write(`ADDR_T2_COUNT, 32'h000000FE);
      apb_write(`ADDR_T2_CTRL, 32'h00000049);
      step2(8'hFF);
      step2(8'h00);
      // PWM up/down turns at 255 and at 0
      apb_write(`ADDR_T2_CTRL, 32'h00000000);
      apb_write(`ADDR_T2_COUNT, 32'h000000FE);
      apb_write(`ADDR_T2_CTRL, 32'h00000041);
      step2(8'hFF);
      step2(8'hFE);
      apb_write(`ADDR_T2_COUNT, 32'h00000001);
      step2(8'h00);
      step2(8'h01);
      final_report();
   end
endmodule : tb_dual_prescaled_timer_counters
